/* File: logic/rsc_top.sv */
// Reset strap loader: captures straps, holds post-reset config, pin sharing.
// Assumes a plain register port on core_clk and strap pins from the board.
//
// How it works
// - Straps must hold through reset; values are taken at reset release.
// - Lane correction off: narrow memory data always on the lowest lane.
// - Lane correction on: narrow data on top lane in big-endian only.
// - Byte-order strap 0 gives big-endian, 1 gives little-endian.
// - Boot field: 00 host boot, else ROM boot at 8, 16, 32 bits.
// - Clock-kind strap 1 means square wave; 0 is reserved.
// - Software-writable config register for settings without a strap.
// - Shared pin is half-rate clock until enabled and set as GPIO.
// - Interrupts 7..4 pass only when pins enabled, inputs, and unmasked.
// - Config bit 4 picks memory clock: 0 internal, 1 external pin.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_top
	import rsc_pkg::*;
#(
	parameter int GP_W = 8
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire rsc_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	input wire logic [15:0] host_data_in,
	input wire logic clock_kind_pin,
	input wire rsc_mem_req_t mem_req,
	output rsc_mem_bus_t ext_bus,
	input wire logic [GP_W-1:0] gp_pin_in,
	input wire logic [3:0] core_int_enable,
	output logic [3:0] irq_to_core,
	output logic gp2_out,
	output logic gp2_oe_n,
	output logic byte_order_select,
	output logic byte_lane_correction,
	output logic boot_from_host,
	output rsc_boot_t boot_mode,
	output logic clock_kind_square,
	output logic clock_kind_reserved,
	output logic mem_clk_from_pin,
	output logic straps_valid
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration check
	if (GP_W != 8) begin : g_bad_width
		$error("rsc_top: GP_W must be 8");
	end

	////////////////////////////////////////////////////////////////////////
	// Register select codes
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_CFG = 3'h1;
	localparam logic [2:0] SEL_STRAP = 3'h2;
	localparam logic [2:0] SEL_GPIO_ENABLE_REGISTER = 3'h3;
	localparam logic [2:0] SEL_GPIO_DIRECTION_REGISTER = 3'h4;
	localparam logic [2:0] SEL_GPVAL = 3'h5;

	// Reset state
	localparam rsc_straps_t STRAP_RST = '{
		lane_corr: `RSC_LANE_RST,
		little: `RSC_ORDER_RST,
		boot: rsc_boot_t'(`RSC_BOOT_RST),
		clk_square: `RSC_CLK_RST
	};
	localparam rsc_state_t STATE_RST = '{
		phase: RSC_HOLD,
		straps: STRAP_RST,
		boot_host: 1'b0,
		clk_rsv: 1'b0,
		mem_clk_pin: `RSC_CFG_RST,
		gp_en: `RSC_GP_RST,
		gp_dir: `RSC_GP_RST,
		gp_val: `RSC_GP_RST,
		rdata: 32'h00000000,
		half_clk: 1'b0,
		ext: '{data: 32'h00000000, be: 4'h0, valid: 1'b0},
		irq: 4'h0,
		gp2_out: 1'b0,
		gp2_oe_n: 1'b0
	};

	// Address decode shared by reads and writes
	function automatic logic [2:0] reg_sel(input logic [31:0] a);
		case (a)
		`RSC_CFG_ADDR: reg_sel = SEL_CFG;
		`RSC_STRAP_ADDR: reg_sel = SEL_STRAP;
		`RSC_GPIO_ENABLE_REGISTER_ADDR: reg_sel = SEL_GPIO_ENABLE_REGISTER;
		`RSC_GPIO_DIRECTION_REGISTER_ADDR: reg_sel = SEL_GPIO_DIRECTION_REGISTER;
		`RSC_GPVAL_ADDR: reg_sel = SEL_GPVAL;
		default: reg_sel = SEL_NONE;
		endcase
	endfunction

	rsc_state_t s;
	rsc_state_t next_s;
	rsc_pins_t pins_raw;
	rsc_pins_t pins_sync;
	logic [GP_W-1:0] gp_sync;
	rsc_mem_bus_t steered;
	logic [3:0] irq_allow;
	logic [2:0] wsel;
	logic [2:0] rsel;
	logic [31:0] strap_word;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	assign pins_raw = '{
		clk_kind: clock_kind_pin,
		lane: host_data_in[`RSC_HD_LANE_BIT],
		order: host_data_in[`RSC_HD_ORDER_BIT],
		boot: host_data_in[`RSC_HD_BOOT_HI:`RSC_HD_BOOT_LO]
	};

	rsc_sync2 #(
		.W($bits(rsc_pins_t))
	) u_strap_sync (
		.core_clk(core_clk),
		.d(pins_raw),
		.q(pins_sync)
	);

	rsc_sync2 #(
		.W(GP_W)
	) u_gp_sync (
		.core_clk(core_clk),
		.d(gp_pin_in),
		.q(gp_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Lane placement from the captured straps
	rsc_lane_steer u_steer (
		.lane_corr(s.straps.lane_corr),
		.little(s.straps.little),
		.req(mem_req),
		.bus(steered)
	);

	////////////////////////////////////////////////////////////////////////
	// Decode and helper terms
	assign wsel = reg_sel(reg_req.addr);
	assign rsel = wsel;
	assign strap_word = {26'h0, s.phase[0], s.straps.clk_square,
		s.straps.boot, s.straps.lane_corr, s.straps.little};

	// Interrupt gate per line: enabled, input, unmasked
	genvar gi;
	for (gi = 0; gi < 4; gi++) begin : g_irq
		assign irq_allow[gi] = gp_sync[`RSC_GP_INT_LO + gi] &
			s.gp_en[`RSC_GP_INT_LO + gi] &
			~s.gp_dir[`RSC_GP_INT_LO + gi] & core_int_enable[gi];
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_s = s;
		next_s.half_clk = ~s.half_clk;

		// Strap capture on the first edge after reset release
		case (s.phase)
		RSC_HOLD: begin
			next_s.straps.lane_corr = pins_sync.lane;
			next_s.straps.little = pins_sync.order;
			next_s.straps.boot = rsc_boot_t'(pins_sync.boot);
			next_s.boot_host = (pins_sync.boot == 2'b00);
			next_s.straps.clk_square = pins_sync.clk_kind;
			next_s.clk_rsv = ~pins_sync.clk_kind;
			next_s.phase = RSC_RUN;
		end
		RSC_RUN: begin
			next_s.phase = RSC_RUN;
		end
		default: begin
			next_s.phase = RSC_HOLD;
		end
		endcase

		// Register writes; reserved bits are dropped
		if (reg_req.wr) begin
			case (wsel)
			SEL_CFG: begin
				next_s.mem_clk_pin = reg_req.wdata[`RSC_CFG_MEMCLK_BIT];
			end
			SEL_GPIO_ENABLE_REGISTER: begin
				next_s.gp_en = reg_req.wdata[7:0] & `RSC_GP_MASK;
			end
			SEL_GPIO_DIRECTION_REGISTER: begin
				next_s.gp_dir = reg_req.wdata[7:0] & `RSC_GP_MASK;
			end
			SEL_GPVAL: begin
				next_s.gp_val = reg_req.wdata[7:0] & `RSC_GP_MASK;
			end
			default: begin
			end
			endcase
		end

		// Read data stands for one cycle only
		next_s.rdata = 32'h00000000;
		if (reg_req.rd) begin
			case (rsel)
			SEL_CFG: begin
				next_s.rdata[`RSC_CFG_MEMCLK_BIT] = s.mem_clk_pin;
			end
			SEL_STRAP: next_s.rdata = strap_word;
			SEL_GPIO_ENABLE_REGISTER: next_s.rdata[7:0] = s.gp_en;
			SEL_GPIO_DIRECTION_REGISTER: next_s.rdata[7:0] = s.gp_dir;
			SEL_GPVAL: next_s.rdata[7:0] = gp_sync & `RSC_GP_MASK;
			default: next_s.rdata = 32'h00000000;
			endcase
		end

		// Lane-placed memory data, registered
		next_s.ext = steered;

		// Shared pin: clock unless enabled as GPIO
		if (s.gp_en[`RSC_GP_SHARED_BIT]) begin
			next_s.gp2_oe_n = ~s.gp_dir[`RSC_GP_SHARED_BIT];
			next_s.gp2_out = s.gp_dir[`RSC_GP_SHARED_BIT] &
				s.gp_val[`RSC_GP_SHARED_BIT];
		end else begin
			next_s.gp2_oe_n = 1'b0;
			next_s.gp2_out = next_s.half_clk;
		end

		// Interrupt forwarding
		next_s.irq = irq_allow;
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register
	assign reg_rdata = s.rdata;
	assign ext_bus = s.ext;
	assign irq_to_core = s.irq;
	assign gp2_out = s.gp2_out;
	assign gp2_oe_n = s.gp2_oe_n;
	assign byte_order_select = s.straps.little;
	assign byte_lane_correction = s.straps.lane_corr;
	assign boot_from_host = s.boot_host;
	assign boot_mode = s.straps.boot;
	assign clock_kind_square = s.straps.clk_square;
	assign clock_kind_reserved = s.clk_rsv;
	assign mem_clk_from_pin = s.mem_clk_pin;
	assign straps_valid = s.phase[0];

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_strap_capture: assert property (
		@(posedge core_clk) disable iff (rst)
		!rst && s.phase == RSC_HOLD |=> straps_valid &&
			boot_mode == $past(pins_sync.boot) &&
			byte_lane_correction == $past(pins_sync.lane) &&
			byte_order_select == $past(pins_sync.order))
		else $error("straps not taken at reset release");

	a_straps_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		straps_valid |=> $stable(byte_order_select) &&
			$stable(byte_lane_correction) && $stable(boot_mode) &&
			$stable(clock_kind_square))
		else $error("captured straps changed after release");

	a_low_lane: assert property (
		@(posedge core_clk) disable iff (rst)
		ext_bus.valid && !byte_lane_correction |-> ext_bus.be[0])
		else $error("narrow data off the low lane");

	a_high_lane: assert property (
		@(posedge core_clk) disable iff (rst)
		mem_req.req &&
			(mem_req.size == RSC_SZ_8 || mem_req.size == RSC_SZ_16) &&
			byte_lane_correction && !byte_order_select
			|=> ext_bus.be[3] && !ext_bus.be[0])
		else $error("big-endian narrow data not on top lane");

	a_boot_decode: assert property (
		@(posedge core_clk) disable iff (rst)
		straps_valid |-> boot_from_host == (boot_mode == RSC_BOOT_HOST))
		else $error("boot source decode wrong");

	a_clock_kind: assert property (
		@(posedge core_clk) disable iff (rst)
		straps_valid |-> clock_kind_reserved != clock_kind_square)
		else $error("clock kind flags disagree");

	a_cfg_write: assert property (
		@(posedge core_clk) disable iff (rst)
		reg_req.wr && wsel == SEL_CFG |=>
			mem_clk_from_pin == $past(reg_req.wdata[`RSC_CFG_MEMCLK_BIT]))
		else $error("memory clock select not written");

	a_cfg_read: assert property (
		@(posedge core_clk) disable iff (rst)
		reg_req.rd && rsel == SEL_CFG |=>
			reg_rdata == {27'h0, $past(mem_clk_from_pin), 4'h0})
		else $error("config read wrong");

	a_pin_clock: assert property (
		@(posedge core_clk) disable iff (rst)
		!s.gp_en[`RSC_GP_SHARED_BIT] ##1 !s.gp_en[`RSC_GP_SHARED_BIT] |=>
			!gp2_oe_n && gp2_out != $past(gp2_out))
		else $error("shared pin not toggling as clock");

	a_irq_gate: assert property (
		@(posedge core_clk) disable iff (rst)
		(irq_to_core & ~($past(core_int_enable) &
			$past(gp_sync[`RSC_GP_INT_LO +: 4]) &
			$past(s.gp_en[`RSC_GP_INT_LO +: 4]) &
			~$past(s.gp_dir[`RSC_GP_INT_LO +: 4]))) == 4'h0)
		else $error("interrupt passed without enable");
endmodule

/* File: logic/rsc_defs.svh */
// Register offsets, field positions and reset values of the strap loader.
// Assumes byte addresses on a 32-bit register port.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// Register byte addresses
`define RSC_CFG_ADDR 32'h019c0200
`define RSC_STRAP_ADDR 32'h019c0204
`define RSC_GPIO_ENABLE_REGISTER_ADDR 32'h01b00000
`define RSC_GPIO_DIRECTION_REGISTER_ADDR 32'h01b00004
`define RSC_GPVAL_ADDR 32'h01b00008

// Field positions
`define RSC_CFG_MEMCLK_BIT 4
`define RSC_GP_SHARED_BIT 2
`define RSC_GP_INT_LO 4
`define RSC_GP_MASK 8'hf4
`define RSC_HD_LANE_BIT 12
`define RSC_HD_ORDER_BIT 8
`define RSC_HD_BOOT_HI 4
`define RSC_HD_BOOT_LO 3
`define RSC_ST_ORDER_BIT 0
`define RSC_ST_LANE_BIT 1
`define RSC_ST_BOOT_LO 2
`define RSC_ST_BOOT_HI 3
`define RSC_ST_CLK_BIT 4
`define RSC_ST_VALID_BIT 5

// Reset values
`define RSC_CFG_RST 1'b0
`define RSC_GP_RST 8'h00
`define RSC_LANE_RST 1'b1
`define RSC_ORDER_RST 1'b1
`define RSC_BOOT_RST 2'b01
`define RSC_CLK_RST 1'b1

`endif

/* File: logic/rsc_pkg.sv */
// Types shared by the strap loader and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package rsc_pkg;

	// Strap capture phase, Gray coded
	typedef enum logic [1:0] {
		RSC_HOLD = 2'b00,
		RSC_RUN = 2'b01
	} rsc_phase_t;

	// Access size on the external memory bus: 8, 16 or 32 bits
	typedef enum logic [1:0] {
		RSC_SZ_8 = 2'b00,
		RSC_SZ_16 = 2'b01,
		RSC_SZ_32 = 2'b10
	} rsc_size_t;

	// Boot source decode
	typedef enum logic [1:0] {
		RSC_BOOT_HOST = 2'b00,
		RSC_BOOT_ROM8 = 2'b01,
		RSC_BOOT_ROM16 = 2'b10,
		RSC_BOOT_ROM32 = 2'b11
	} rsc_boot_t;

	// Strap pins as sampled
	typedef struct packed {
		logic clk_kind;
		logic lane;
		logic order;
		logic [1:0] boot;
	} rsc_pins_t;

	// Captured strap settings
	typedef struct packed {
		logic lane_corr;
		logic little;
		rsc_boot_t boot;
		logic clk_square;
	} rsc_straps_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rsc_reg_req_t;

	// External memory request from the memory controller
	typedef struct packed {
		logic req;
		rsc_size_t size;
		logic [31:0] wdata;
	} rsc_mem_req_t;

	// Lane-placed external data
	typedef struct packed {
		logic [31:0] data;
		logic [3:0] be;
		logic valid;
	} rsc_mem_bus_t;

	// Whole state of the top module
	typedef struct packed {
		rsc_phase_t phase;
		rsc_straps_t straps;
		logic boot_host;
		logic clk_rsv;
		logic mem_clk_pin;
		logic [7:0] gp_en;
		logic [7:0] gp_dir;
		logic [7:0] gp_val;
		logic [31:0] rdata;
		logic half_clk;
		rsc_mem_bus_t ext;
		logic [3:0] irq;
		logic gp2_out;
		logic gp2_oe_n;
	} rsc_state_t;

endpackage

/* File: logic/rsc_sync2.sv */
// Two-flop synchroniser for pin levels.
// Assumes slowly changing levels; no reset, the pipe fills while reset is held.
`timescale 1ns/1ps
module rsc_sync2 #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// Elaboration check
	if (W < 1) begin : g_bad_width
		$error("rsc_sync2: W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////
	// First stage feeds only the second
	always_ff @(posedge core_clk) begin
		meta <= d;
		q <= meta;
	end
endmodule

/* File: logic/rsc_lane_steer.sv */
// Places narrow external-memory write data on a byte lane.
// Assumes the caller registers the result.
`timescale 1ns/1ps
module rsc_lane_steer
	import rsc_pkg::*;
(
	input wire logic lane_corr,
	input wire logic little,
	input wire rsc_mem_req_t req,
	output rsc_mem_bus_t bus
);
	logic high;

	////////////////////////////////////////////////////////////////////////
	// High lane only with correction on in big-endian order
	assign high = lane_corr & ~little;

	always_comb begin
		bus.valid = req.req;
		case (req.size)
		RSC_SZ_8: begin
			bus.be = high ? 4'h8 : 4'h1;
			bus.data = high ? {req.wdata[7:0], 24'h000000} :
				{24'h000000, req.wdata[7:0]};
		end
		RSC_SZ_16: begin
			bus.be = high ? 4'hc : 4'h3;
			bus.data = high ? {req.wdata[15:0], 16'h0000} :
				{16'h0000, req.wdata[15:0]};
		end
		default: begin
			bus.be = 4'hf;
			bus.data = req.wdata;
		end
		endcase
	end
endmodule

/* File: sim/rsc_board.sv */
// Board model: strap resistors on the host data pins and the reset source.
// Assumes the bench asks for reset; all changes land just after core_clk rises.
`timescale 1ns/1ps
module rsc_board
	import rsc_pkg::*;
(
	input wire logic core_clk,
	input wire logic hold_req,
	input wire rsc_pins_t straps,
	output logic rst,
	output logic [15:0] host_data_in,
	output logic clock_kind_pin
);
	////////////////////////////////////////////////////////////////////////
	// Start in reset with default straps
	initial begin
		rst = 1'b1;
		host_data_in = 16'h0000;
		clock_kind_pin = 1'b1;
	end

	// Straps stand through reset; the host reuses the pins right after it
	always @(posedge core_clk) begin
		rst <= hold_req;
		clock_kind_pin <= straps.clk_kind;
		if (hold_req) begin
			host_data_in <= {3'h0, straps.lane, 3'h0, straps.order, 3'h0,
				straps.boot, 3'h0};
		end else begin
			host_data_in <= ~host_data_in;
		end
	end
endmodule

/* File: sim/tb.sv */
// Bench for the strap loader: straps, lane placement, config and shared pins.
// Assumes the board model drives reset and the strap pins.
`timescale 1ns/1ps
`include "rsc_defs.svh"
module tb
	import rsc_pkg::*;
;
	logic core_clk = 1'b0;
	logic hold_req = 1'b1;
	rsc_pins_t straps = 5'b11101;
	logic rst, gp2_out, gp2_oe_n, byte_order_select, byte_lane_correction;
	logic boot_from_host, clock_kind_square, clock_kind_reserved;
	logic mem_clk_from_pin, straps_valid, clock_kind_pin;
	logic [15:0] host_data_in;
	logic [31:0] reg_rdata, rd_val;
	logic [7:0] gp_pin_in = 8'h00;
	logic [3:0] core_int_enable = 4'h0;
	logic [3:0] irq_to_core;
	rsc_reg_req_t reg_req = '0;
	rsc_mem_req_t mem_req = '0;
	rsc_mem_bus_t ext_bus;
	rsc_boot_t boot_mode;
	int mismatches = 0;
	int check_count = 0;
	// Expected lane data and enables for sizes 8, 16, 32 and code 11
	logic [31:0] dlo [4] = '{32'h78, 32'h5678, 32'h12345678, 32'h12345678};
	logic [31:0] dhi [4] = '{32'h78000000, 32'h56780000, 32'h12345678,
		32'h12345678};
	logic [3:0] belo [4] = '{4'h1, 4'h3, 4'hf, 4'hf};
	logic [3:0] behi [4] = '{4'h8, 4'hc, 4'hf, 4'hf};
	rsc_pins_t cases [4] = '{5'b11101, 5'b11010, 5'b10011, 5'b10100};

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	rsc_board u_rsc_board (.core_clk(core_clk), .hold_req(hold_req),
		.straps(straps), .rst(rst), .host_data_in(host_data_in),
		.clock_kind_pin(clock_kind_pin));

	rsc_top #(.GP_W(8)) u_rsc_top (.core_clk(core_clk), .rst(rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata),
		.host_data_in(host_data_in), .clock_kind_pin(clock_kind_pin),
		.mem_req(mem_req), .ext_bus(ext_bus), .gp_pin_in(gp_pin_in),
		.core_int_enable(core_int_enable), .irq_to_core(irq_to_core),
		.gp2_out(gp2_out), .gp2_oe_n(gp2_oe_n),
		.byte_order_select(byte_order_select),
		.byte_lane_correction(byte_lane_correction),
		.boot_from_host(boot_from_host), .boot_mode(boot_mode),
		.clock_kind_square(clock_kind_square),
		.clock_kind_reserved(clock_kind_reserved),
		.mem_clk_from_pin(mem_clk_from_pin), .straps_valid(straps_valid));

	////////////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// One-cycle register write
	task reg_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req.wr <= 1'b1;
		reg_req.addr <= a;
		reg_req.wdata <= d;
		@(posedge core_clk);
		reg_req.wr <= 1'b0;
	endtask

	// One-cycle register read, data taken in the following cycle
	task reg_rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_req.rd <= 1'b1;
		reg_req.addr <= a;
		@(posedge core_clk);
		reg_req.rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset with given straps, then check capture and lane placement
	task strap_case(input rsc_pins_t s);
		logic hi;
		hi = s.lane && !s.order;
		@(posedge core_clk);
		hold_req <= 1'b1;
		straps <= s;
		repeat (16) @(posedge core_clk);
		hold_req <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk("order", s.order, byte_order_select);
		chk("lane", s.lane, byte_lane_correction);
		chk("boot", s.boot, boot_mode);
		chk("host boot", s.boot == 2'b00, boot_from_host);
		chk("clock kind", {s.clk_kind, ~s.clk_kind},
			{clock_kind_square, clock_kind_reserved});
		chk("valid", 1, straps_valid);
		reg_rd(`RSC_CFG_ADDR, rd_val);
		chk("cfg reset", 0, rd_val);
		reg_rd(`RSC_STRAP_ADDR, rd_val);
		chk("status", {26'h0, 1'b1, s.clk_kind, s.boot, s.lane, s.order},
			rd_val);
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			mem_req <= '{req: 1'b1, size: rsc_size_t'(i), wdata: 32'h12345678};
			@(posedge core_clk);
			mem_req.req <= 1'b0;
			@(negedge core_clk);
			chk("lane data", hi ? dhi[i] : dlo[i], ext_bus.data);
			chk("lane enables", hi ? behi[i] : belo[i], ext_bus.be);
			chk("lane valid", 1, ext_bus.valid);
		end
	endtask

	// Memory clock select through the config register
	task cfg_case;
		reg_wr(`RSC_CFG_ADDR, 32'h10);
		@(negedge core_clk);
		chk("mem clk pin", 1, mem_clk_from_pin);
		reg_rd(`RSC_CFG_ADDR, rd_val);
		chk("cfg read", 32'h10, rd_val);
		reg_rd(32'h019c0300, rd_val);
		chk("unmapped", 0, rd_val);
	endtask

	// Shared pin takeover and interrupt gating
	task pin_case;
		logic g0;
		@(negedge core_clk);
		g0 = gp2_out;
		@(negedge core_clk);
		chk("half clock", {1'b0, ~g0}, {gp2_oe_n, gp2_out});
		reg_wr(`RSC_GPVAL_ADDR, 32'h04);
		reg_wr(`RSC_GPIO_ENABLE_REGISTER_ADDR, 32'hf4);
		repeat (2) @(negedge core_clk);
		chk("pin input", 1, gp2_oe_n);
		reg_wr(`RSC_GPIO_DIRECTION_REGISTER_ADDR, 32'h04);
		repeat (2) @(negedge core_clk);
		chk("pin output", 2'b01, {gp2_oe_n, gp2_out});
		@(posedge core_clk);
		gp_pin_in <= 8'h10;
		core_int_enable <= 4'h1;
		repeat (4) @(negedge core_clk);
		chk("irq one", 4'h1, irq_to_core);
		@(posedge core_clk);
		gp_pin_in <= 8'hf0;
		core_int_enable <= 4'he;
		repeat (4) @(negedge core_clk);
		chk("irq masked", 4'he, irq_to_core);
		reg_rd(`RSC_GPVAL_ADDR, rd_val);
		chk("pin levels", 32'hf0, rd_val);
		reg_wr(`RSC_GPIO_ENABLE_REGISTER_ADDR, 32'h04);
		repeat (2) @(negedge core_clk);
		chk("irq pins off", 4'h0, irq_to_core);
		reg_wr(`RSC_GPIO_ENABLE_REGISTER_ADDR, 32'hff);
		repeat (2) @(negedge core_clk);
		chk("irq pins on", 4'he, irq_to_core);
		reg_rd(`RSC_GPIO_ENABLE_REGISTER_ADDR, rd_val);
		chk("enable bits", 32'hf4, rd_val);
		reg_wr(`RSC_GPIO_DIRECTION_REGISTER_ADDR, 32'hf4);
		repeat (2) @(negedge core_clk);
		chk("irq outputs", 4'h0, irq_to_core);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task give_verdict;
		$display("checks %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		strap_case(cases[0]);
		pin_case;
		cfg_case;
		for (int k = 1; k < 4; k++) begin
			strap_case(cases[k]);
		end
		give_verdict;
	end

	// Watchdog, well beyond the expected few hundred cycles
	initial begin
		#(2000 * 40);
		mismatches++;
		give_verdict;
	end
endmodule
